// ### pkg/pwr_pkg.sv
package pwr_pkg;
	localparam int NUM_CH    = 24;
	localparam int GRP_CH    = 4;
	localparam int NUM_GRP   = NUM_CH / GRP_CH;
	localparam int NUM_PAIR  = NUM_CH / 2;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int WIDTH_W   = 8;
	localparam int CNT_W     = 16;

	localparam logic [ADDR_W-1:0] RELOAD_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] CTRL_BASE   = 12'h080;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h100;
	localparam logic [ADDR_W-1:0] REGION_MASK = 12'hf80;

	localparam int HI_LSB        = 8;
	localparam int LO_LSB        = 0;
	localparam int CTL_RUN_BIT   = 0;
	localparam int CTL_MODE_LSB  = 9;
	localparam int CTL_CLK_LSB   = 11;
	localparam int IDX_LSB       = 2;
	localparam int IDX_W         = 5;

	localparam int PRE_W                 = 6;
	localparam logic [PRE_W-1:0] DIV4_M  = 6'h03;
	localparam logic [PRE_W-1:0] DIV16_M = 6'h0f;
	localparam logic [PRE_W-1:0] DIV64_M = 6'h3f;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PWR_MODE_8     = 2'b00,
		PWR_MODE_8P8   = 2'b01,
		PWR_MODE_16    = 2'b10,
		PWR_MODE_16P16 = 2'b11
	} pwr_mode_t;

	typedef enum logic [1:0] {
		PWR_CLK_DIV1  = 2'b00,
		PWR_CLK_DIV4  = 2'b01,
		PWR_CLK_DIV16 = 2'b10,
		PWR_CLK_DIV64 = 2'b11
	} pwr_clk_t;

	typedef enum logic {
		PWR_PH_LOW  = 1'b0,
		PWR_PH_HIGH = 1'b1
	} pwr_phase_t;
endpackage : pwr_pkg

// ### hw/pwr_group.sv
`timescale 1ns/1ps
module pwr_group (
	input  wire logic                            ref_clk,
	input  wire logic                            arst_n,
	input  wire logic [3:0][7:0]                 high_width_reload,
	input  wire logic [3:0][7:0]                 low_width_reload,
	input  wire logic [3:0]                      run,
	input  wire logic [3:0]                      cnt_en,
	input  wire logic [1:0]                      pair_mode_select_hi,
	input  wire logic [1:0]                      pair_mode_select_lo,
	output logic      [3:0]                      pulse_out
);
	logic [3:0] uf;
	logic       group_mode;

	// grouping keyed off the first pair
	assign group_mode = ({pair_mode_select_hi[0], pair_mode_select_lo[0]} ==
		pwr_pkg::PWR_MODE_16P16);

	for (genvar c = 0; c < 4; c++) begin : g_ch
		localparam int E = c - (c % 2);
		localparam int O = E + 1;
		logic [1:0]                    mode;
		logic                          joined;
		logic                          active;
		logic                          tick;
		logic [pwr_pkg::CNT_W-1:0]     hi_w;
		logic [pwr_pkg::CNT_W-1:0]     lo_w;
		logic [pwr_pkg::CNT_W-1:0]     cnt_q;
		logic [pwr_pkg::CNT_W-1:0]     hbuf_q;
		pwr_pkg::pwr_phase_t           phase_q;
		logic                          act_q;

		assign mode   = {pair_mode_select_hi[c/2], pair_mode_select_lo[c/2]};
		assign joined = group_mode || (mode == pwr_pkg::PWR_MODE_16);
		// joined pair drives only the even engine
		assign active = joined ? ((c % 2 == 0) && run[E]) : run[c];
		assign hi_w = joined ? {high_width_reload[E], low_width_reload[E]}
			: {8'h00, high_width_reload[c]};
		assign lo_w = joined ? {high_width_reload[O], low_width_reload[O]}
			: {8'h00, low_width_reload[c]};
		assign tick = (group_mode && c == 0) ? uf[2]
			: (!joined && mode == pwr_pkg::PWR_MODE_8P8 && c % 2 == 0) ? uf[O]
			: cnt_en[c];
		assign uf[c] = active && act_q && tick && (cnt_q == '0);
		assign pulse_out[c] = phase_q;

		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				cnt_q   <= '0;
				hbuf_q  <= '0;
				phase_q <= pwr_pkg::PWR_PH_LOW;
				act_q   <= 1'b0;
			end else begin
				act_q <= active;
				if (!active) begin
					phase_q <= pwr_pkg::PWR_PH_LOW;
				end else if (!act_q) begin
					cnt_q   <= lo_w;
					hbuf_q  <= hi_w;
					phase_q <= pwr_pkg::PWR_PH_LOW;
				end else if (uf[c]) begin
					// reload width, counts width plus one
					if (phase_q == pwr_pkg::PWR_PH_LOW) begin
						phase_q <= pwr_pkg::PWR_PH_HIGH;
						cnt_q   <= hbuf_q;
					end else begin
						phase_q <= pwr_pkg::PWR_PH_LOW;
						cnt_q   <= lo_w;
						hbuf_q  <= hi_w;
					end
				end else if (tick) begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule : pwr_group

// ### hw/pwr_top.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module pwr_top (
	input  wire logic                            ref_clk,
	input  wire logic                            arst_n,
	input  wire logic [pwr_pkg::ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [pwr_pkg::DATA_W-1:0]      s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [pwr_pkg::ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [pwr_pkg::DATA_W-1:0]           s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	output logic [pwr_pkg::NUM_CH-1:0]           pulse_out
);
	// register storage
	logic [15:0]                        reload_mem [pwr_pkg::NUM_CH];
	logic [pwr_pkg::NUM_CH-1:0]         run_q;
	logic [1:0]                         clk_sel_q  [pwr_pkg::NUM_CH];
	logic [pwr_pkg::NUM_PAIR-1:0]       mode_hi_q;
	logic [pwr_pkg::NUM_PAIR-1:0]       mode_lo_q;

	// prescaler
	logic [pwr_pkg::PRE_W-1:0]          pre_q;
	logic [pwr_pkg::NUM_CH-1:0]         cnt_en;
	logic [pwr_pkg::NUM_CH-1:0][7:0]    hw_bus;
	logic [pwr_pkg::NUM_CH-1:0][7:0]    lw_bus;

	// write channel state
	logic                               aw_held_q;
	logic                               w_held_q;
	logic [pwr_pkg::ADDR_W-1:0]         awaddr_q;
	logic [pwr_pkg::DATA_W-1:0]         wdata_q;
	logic [3:0]                         wstrb_q;
	logic                               do_write;
	logic                               wr_reload;
	logic                               wr_ctrl;
	logic [pwr_pkg::IDX_W-1:0]          wr_idx;
	logic                               wr_idx_ok;

	assign wr_idx    = awaddr_q[pwr_pkg::IDX_LSB +: pwr_pkg::IDX_W];
	assign wr_idx_ok = (32'(wr_idx) < pwr_pkg::NUM_CH);
	assign do_write  = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_reload = do_write && wr_idx_ok &&
		((awaddr_q & pwr_pkg::REGION_MASK) == pwr_pkg::RELOAD_BASE);
	assign wr_ctrl   = do_write && wr_idx_ok &&
		((awaddr_q & pwr_pkg::REGION_MASK) == pwr_pkg::CTRL_BASE);

	// count clock enables, one-cycle pulses from a free divider
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 6'h01;
		end
	end

	for (genvar n = 0; n < pwr_pkg::NUM_CH; n++) begin : g_ch
		always_comb begin
			case (pwr_pkg::pwr_clk_t'(clk_sel_q[n]))
				pwr_pkg::PWR_CLK_DIV1:  cnt_en[n] = 1'b1;
				pwr_pkg::PWR_CLK_DIV4:  cnt_en[n] = ((pre_q & pwr_pkg::DIV4_M) == pwr_pkg::DIV4_M);
				pwr_pkg::PWR_CLK_DIV16: cnt_en[n] = ((pre_q & pwr_pkg::DIV16_M) == pwr_pkg::DIV16_M);
				pwr_pkg::PWR_CLK_DIV64: cnt_en[n] = (pre_q == pwr_pkg::DIV64_M);
				default:                cnt_en[n] = 1'b1;
			endcase
		end
		// high byte upper, low byte lower
		assign hw_bus[n] = reload_mem[n][pwr_pkg::HI_LSB +: pwr_pkg::WIDTH_W];
		assign lw_bus[n] = reload_mem[n][pwr_pkg::LO_LSB +: pwr_pkg::WIDTH_W];
	end

	// widths store any value, no reset
	// writable at any time, even while running
	always_ff @(posedge ref_clk) begin
		if (wr_reload) begin
			if (wstrb_q[0]) begin
				reload_mem[wr_idx][pwr_pkg::LO_LSB +: pwr_pkg::WIDTH_W] <= wdata_q[7:0];
			end
			if (wstrb_q[1]) begin
				reload_mem[wr_idx][pwr_pkg::HI_LSB +: pwr_pkg::WIDTH_W] <= wdata_q[15:8];
			end
		end
	end

	// control registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q     <= '0;
			mode_hi_q <= '0;
			mode_lo_q <= '0;
			for (int i = 0; i < pwr_pkg::NUM_CH; i++) begin
				clk_sel_q[i] <= 2'h0;
			end
		end else if (wr_ctrl) begin
			if (wstrb_q[0]) begin
				run_q[wr_idx] <= wdata_q[pwr_pkg::CTL_RUN_BIT];
			end
			if (wstrb_q[1]) begin
				clk_sel_q[wr_idx] <= wdata_q[pwr_pkg::CTL_CLK_LSB +: 2];
				// mode held by even channel only
				if (!wr_idx[0]) begin
					mode_lo_q[wr_idx[pwr_pkg::IDX_W-1:1]] <= wdata_q[pwr_pkg::CTL_MODE_LSB];
					mode_hi_q[wr_idx[pwr_pkg::IDX_W-1:1]] <= wdata_q[pwr_pkg::CTL_MODE_LSB+1];
				end
			end
		end
	end

	// same grouping repeated per four channels
	for (genvar g = 0; g < pwr_pkg::NUM_GRP; g++) begin : g_grp
		pwr_group u_group (
			.ref_clk             (ref_clk),
			.arst_n              (arst_n),
			.high_width_reload   (hw_bus[g*4 +: 4]),
			.low_width_reload    (lw_bus[g*4 +: 4]),
			.run                 (run_q[g*4 +: 4]),
			.cnt_en              (cnt_en[g*4 +: 4]),
			.pair_mode_select_hi (mode_hi_q[g*2 +: 2]),
			.pair_mode_select_lo (mode_lo_q[g*2 +: 2]),
			.pulse_out           (pulse_out[g*4 +: 4])
		);
	end

	// write address/data taken in either order, response after both
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pwr_pkg::RESP_OKAY;
		end else begin
			if (!aw_held_q && !s_axi_bvalid && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
			end
			if (!w_held_q && !s_axi_bvalid && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_reload || wr_ctrl) ? pwr_pkg::RESP_OKAY
					: pwr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read decode; unmapped answers slverr with zero data
	logic [pwr_pkg::IDX_W-1:0]  rd_idx;
	logic                       rd_idx_ok;
	logic [pwr_pkg::DATA_W-1:0] rd_data;
	logic [1:0]                 rd_resp;

	assign rd_idx    = s_axi_araddr[pwr_pkg::IDX_LSB +: pwr_pkg::IDX_W];
	assign rd_idx_ok = (32'(rd_idx) < pwr_pkg::NUM_CH);

	always_comb begin
		rd_data = '0;
		rd_resp = pwr_pkg::RESP_OKAY;
		if (s_axi_araddr == pwr_pkg::STATUS_ADDR) begin
			rd_data = 32'(pulse_out);
		end else if (rd_idx_ok &&
			(s_axi_araddr & pwr_pkg::REGION_MASK) == pwr_pkg::RELOAD_BASE) begin
			rd_data = 32'(reload_mem[rd_idx]);
		end else if (rd_idx_ok &&
			(s_axi_araddr & pwr_pkg::REGION_MASK) == pwr_pkg::CTRL_BASE) begin
			rd_data[pwr_pkg::CTL_RUN_BIT]       = run_q[rd_idx];
			rd_data[pwr_pkg::CTL_CLK_LSB +: 2]  = clk_sel_q[rd_idx];
			if (!rd_idx[0]) begin
				rd_data[pwr_pkg::CTL_MODE_LSB]   = mode_lo_q[rd_idx[pwr_pkg::IDX_W-1:1]];
				rd_data[pwr_pkg::CTL_MODE_LSB+1] = mode_hi_q[rd_idx[pwr_pkg::IDX_W-1:1]];
			end
		end else begin
			rd_resp = pwr_pkg::RESP_SLVERR;
		end
	end

	// undefined widths may read as x until software writes them
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= pwr_pkg::RESP_OKAY;
		end else begin
			if (!s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_data;
				s_axi_rresp   <= rd_resp;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : pwr_top

// ### bench/pwr_properties.sv
`timescale 1ns/1ps
module pwr_properties (
	input wire logic	ref_clk,
	input wire logic	arst_n,
	input wire logic [11:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic [11:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic [23:0]	pulse_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic	aw_bad_q;
	logic	ar_bad_q;
	// reload words, control words and status are the only mapped places
	function automatic logic bad_addr(input logic [11:0] a);
		return !(a < 12'h060 || (a >= 12'h080 && a < 12'h0e0) || a == 12'h100);
	endfunction : bad_addr
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) aw_bad_q <= 1'b0;
		// status is read-only, so a write there is refused as well
		else if (s_axi_awvalid && s_axi_awready)
			aw_bad_q <= bad_addr(s_axi_awaddr) || s_axi_awaddr == 12'h100;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) ar_bad_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready) ar_bad_q <= bad_addr(s_axi_araddr);
	end
	sequence b_taken;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence wr_reopen;
		!s_axi_bvalid && s_axi_awready && s_axi_wready;
	endsequence
	wr_resp_code_a: assert property ($rose(s_axi_bvalid) |->
		s_axi_bresp == (aw_bad_q ? 2'h2 : 2'h0)) else $error("wrong write response");
	rd_resp_code_a: assert property ($rose(s_axi_rvalid) |->
		s_axi_rresp == (ar_bad_q ? 2'h2 : 2'h0) && (!ar_bad_q || s_axi_rdata == '0))
		else $error("wrong read response");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	bresp_drop_a: assert property (b_taken |=> !s_axi_bvalid)
		else $error("write response not retired");
	rdata_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not retired");
	aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high");
	// ready comes back one edge after the response is retired
	wr_reopen_a: assert property (b_taken |=> !s_axi_bvalid ##1 wr_reopen)
		else $error("write channel not reopened");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("late read answer");
	start_low_a: assert property ($rose(arst_n) |-> pulse_out == '0)
		else $error("output not low after reset");
endmodule : pwr_properties

bind pwr_top pwr_properties u_props (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.pulse_out);

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
	logic		ref_clk = 1'b0;
	logic		arst_n = 1'b0;
	logic [11:0]	s_axi_awaddr = '0;
	logic [11:0]	s_axi_araddr = '0;
	logic [31:0]	s_axi_wdata = '0;
	logic [3:0]	s_axi_wstrb = '0;
	logic		s_axi_awvalid = 1'b0;
	logic		s_axi_wvalid = 1'b0;
	logic		s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0;
	logic		s_axi_rready = 1'b0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_rdata;
	logic [23:0]	pulse_out;
	int		n_mismatch = 0;
	int		samples_checked = 0;
	int		rl [24];
	pwr_top uut (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pulse_out);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic tmo();
		n_mismatch++;
		finish_test();
	endtask : tmo
	// ready stands from the start; one idle edge at the end keeps calls apart
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 99);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
		if (n >= 99) tmo();
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 99);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
		if (n >= 99) tmo();
	endtask : rd
	task automatic cfg(input int c, input logic [15:0] w, input logic [15:0] ctl);
		logic [1:0] r;
		wr(12'(4 * c), {16'h0, w}, 4'h3, r);
		wr(12'(12'h080 + 4 * c), {16'h0, ctl}, 4'h3, r);
	endtask : cfg
	// skips the phase under way, then counts one whole phase at level lv
	task automatic ph(input int ch, input logic lv, input int e);
		int n;
		int len;
		for (n = 0; pulse_out[ch] === lv && n < 9000; n++) @(posedge ref_clk);
		for (; pulse_out[ch] !== lv && n < 9000; n++) @(posedge ref_clk);
		for (len = 0; pulse_out[ch] === lv && n < 9000; n++, len++) @(posedge ref_clk);
		if (n >= 9000) tmo();
		else `CHK("phase", e, len)
	endtask : ph
	initial begin
		repeat (100000) @(posedge ref_clk);
		tmo();
	end
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int h, l, p, h2;
		void'($urandom(18));
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		for (int c = 0; c < 24; c++) begin
			rl[c] = $urandom & 'hffff;
			wr(12'(4 * c), 32'(rl[c]), 4'h3, r);
		end
		// byte strobes: low byte alone, then high byte alone
		for (int c = 4; c < 6; c++) begin
			d = $urandom;
			wr(12'(4 * c), d, 4'(c - 3), r);
			rl[c] = (c == 4) ? (rl[c] & 'hff00) | (d & 'hff) : (rl[c] & 'hff) | (d & 'hff00);
		end
		for (int c = 0; c < 26; c++) begin
			rd(12'(4 * c), d, r);
			`CHK("reload", (c < 24) ? 32'(rl[c]) : 32'h0, d)
			`CHK("read resp", (c < 24) ? 2'h0 : 2'h2, r)
		end
		wr(12'h064, 32'h0, 4'h3, r);
		`CHK("bad write", 2'h2, r)
		h = 8 + $urandom % 16;
		l = 8 + $urandom % 16;
		cfg(0, 16'(h * 256 + l), 16'h0001);
		ph(0, 1'b1, h + 1);
		ph(0, 1'b0, l + 1);
		h2 = $urandom % 256;
		wr(12'h000, 32'(h2 * 256), 4'h2, r);
		ph(0, 1'b1, h2 + 1);
		wr(12'h000, 32'(h * 256), 4'h2, r);
		ph(0, 1'b1, h2 + 1);
		ph(0, 1'b1, h + 1);
		p = $urandom % 8;
		cfg(1, 16'(p * 256 + 3), 16'h0801);
		ph(1, 1'b1, (p + 1) * 4);
		h = 'h100 + $urandom % 64;
		l = 'h100 + $urandom % 64;
		cfg(3, 16'(l), 16'h0000);
		cfg(2, 16'(h), 16'h0401);
		ph(2, 1'b1, h + 1);
		ph(2, 1'b0, l + 1);
		p = $urandom % 4;
		h = $urandom % 8;
		l = $urandom % 8;
		cfg(21, 16'(p * 257), 16'h0001);
		cfg(20, 16'(h * 256 + l), 16'h0201);
		ph(20, 1'b1, (h + 1) * (p + 1));
		ph(20, 1'b0, (l + 1) * (p + 1));
		h = 'h100 + $urandom % 8;
		cfg(11, 16'(p), 16'h0000);
		cfg(10, 16'(p), 16'h0601);
		cfg(9, 16'h0005, 16'h0000);
		cfg(8, 16'(h), 16'h0601);
		ph(8, 1'b1, (h + 1) * (p + 1));
		ph(8, 1'b0, 6 * (p + 1));
		rd(12'h0a0, d, r);
		`CHK("control", 32'h0601, d)
		cfg(16, 16'h0100, 16'h1001);
		ph(16, 1'b1, 32);
		cfg(17, 16'h0001, 16'h1801);
		ph(17, 1'b0, 128);
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		`CHK("outputs", 24'h0, pulse_out)
		rd(12'h100, d, r);
		`CHK("status", 32'h0, d)
		`CHK("status resp", 2'h0, r)
		finish_test();
	end
endmodule : tb
